// [mpc_pkg.sv]
// Package for the multifunction pin configuration block.
// Assumes a byte-wide register port inside the codec, clocked by core_clk.
package mpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_OUT_PIN_FUNCTION_CFG = 8'h0c;
  localparam logic [7:0] ADDR_INPUT_PIN_CFG        = 8'h0d;
  localparam logic [7:0] ADDR_PIN_VALUE_MONITOR    = 8'h0e;

  // Reset values
  localparam logic [7:0] RST_OUT_PIN_FUNCTION_CFG = 8'h00;
  localparam logic [7:0] RST_INPUT_PIN_CFG        = 8'h00;
  localparam logic [7:0] RST_PIN_VALUE_MONITOR    = 8'h00;

  // Field positions
  localparam int FUNC_LSB      = 4;
  localparam int SPEED_SEL_BIT = 3;
  localparam int DRIVE_LSB     = 0;
  localparam int IN_A_EN_BIT   = 1;
  localparam int IN_B_EN_BIT   = 0;
  localparam int IO_A_LVL_BIT  = 7;
  localparam int OUT_B_LVL_BIT = 5;
  localparam int IO_A_MON_BIT  = 3;
  localparam int IN_B_MON_BIT  = 2;
  localparam int IN_A_MON_BIT  = 1;
  localparam logic [7:0] INPUT_CFG_WMASK = 8'h03;
  localparam logic [7:0] VALUE_WMASK     = 8'ha0;

  // Function codes
  localparam logic [3:0] FN_DISABLED  = 4'h0;
  localparam logic [3:0] FN_INPUT     = 4'h1;
  localparam logic [3:0] FN_GP_OUTPUT = 4'h2;
  localparam logic [3:0] FN_IRQ       = 4'h3;
  localparam logic [3:0] FN_ASI_MUXED = 4'hc;
  localparam logic [3:0] FN_DAISY_OUT = 4'hd;

  // Drive codes
  localparam logic [2:0] DRV_HIZ        = 3'h0;
  localparam logic [2:0] DRV_PUSH_PULL  = 3'h1;
  localparam logic [2:0] DRV_LOW_WEAKHI = 3'h2;
  localparam logic [2:0] DRV_LOW_HIZ    = 3'h3;
  localparam logic [2:0] DRV_WEAKLO_HI  = 3'h4;
  localparam logic [2:0] DRV_HIZ_HI     = 3'h5;

  // Toggle limit on the output pin
  localparam int CLK_HZ        = 125_000_000;
  localparam int MAX_TOGGLE_HZ = 6_000_000;
  // Shortest hold between level changes, half a period at the limit, rounded up
  localparam int TOGGLE_GAP_CYC = (CLK_HZ + 2 * MAX_TOGGLE_HZ - 1) / (2 * MAX_TOGGLE_HZ);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpc_reg_req_type;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } mpc_reg_rsp_type;

  // Pad driver control: drive strengths per level
  typedef struct packed {
    logic level;
    logic strong_en;
    logic weak_en;
  } mpc_pad_type;

endpackage : mpc_pkg

// [mpc_sync2.sv]
// Two-flop synchroniser for pin levels entering the core_clk domain.
// Assumes a free-running core_clk and synchronous active-low reset.
module mpc_sync2 #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1)
  begin : g_width_chk
    $error("WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } mpc_sync_state_type;

  mpc_sync_state_type st_q;
  mpc_sync_state_type st_d;

  always_comb
  begin
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule // mpc_sync2

// [mpc_toggle_limit.sv]
// Holds each change of the output level for a minimum number of cycles.
// Assumes the level is produced on core_clk; the first change passes at once.
module mpc_toggle_limit #(
  parameter int GAP_CYC = 11
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Level
  input  wire logic level_in,
  output logic      level_out
);

  localparam int CW = $clog2(GAP_CYC + 1);

  if (GAP_CYC < 1)
  begin : g_gap_chk
    $error("GAP_CYC must be at least 1");
  end

  typedef struct packed {
    logic          level;
    logic [CW-1:0] hold;
  } mpc_tl_state_type;

  mpc_tl_state_type st_q;
  mpc_tl_state_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (st_q.hold != '0)
      st_d.hold = st_q.hold - CW'(1);
    else if (level_in != st_q.level)
    begin
      st_d.level = level_in;
      st_d.hold  = CW'(GAP_CYC - 1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level_out = st_q.level;

endmodule // mpc_toggle_limit

// [mpc_pin_config.sv]
// Configuration and value logic for the four multifunction pins.
// Assumes a same-clock byte register port, pin inputs from the pads
// (synchronised here) and function sources from the core on core_clk.

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Function codes 0,1,2: disabled, input, output
// - Code 3 drives chip interrupt request out
// - Code 12 drives muxed serial audio data
// - Code 13 drives daisy-chain data output
// - Output pin toggles no faster than 6 MHz, except peripheral data-out with speed bit set
// - Peripheral mode: pin is data-out, function ignored
// - No bus-keeper while carrying serial audio
// - Speed bit clear: limited peripheral data-out
// - Speed bit set: high-speed peripheral data-out
// - Drive codes 0..5 select pad drive style
// - Peripheral mode: drive field ignored, chip-select
// - Input config bit 1 enables input A
// - Input config bit 0 enables input B
// - Input config bits 7-2 read zero
// - Value bits 7,5 writable; 6,4,0 read zero
// - Output function drives value bit level
// - Monitor bits 3,2,1 show sampled input levels
module mpc_pin_config (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Register port
  input  wire mpc_pkg::mpc_reg_req_type reg_req,
  output mpc_pkg::mpc_reg_rsp_type      reg_rsp,
  // Control interface mode
  input  wire logic                     periph_mode,
  input  wire logic                     periph_dataout,
  input  wire logic                     periph_dataout_en,
  // Internal function sources
  input  wire logic                     irq_level,
  input  wire logic                     primary_serial_audio_port_dout,
  input  wire logic                     secondary_serial_audio_port_dout,
  input  wire logic                     secondary_dout_sel,
  input  wire logic                     daisy_dout,
  input  wire logic                     io_a_out_en,
  // Pin levels from pads
  input  wire logic                     io_pin_a_in,
  input  wire logic                     in_pin_a_in,
  input  wire logic                     in_pin_b_in,
  input  wire logic                     out_pin_b_in,
  // Out pin B pad control
  output mpc_pkg::mpc_pad_type          out_pin_b_pad,
  output logic                          out_pin_b_keeper_en,
  output logic                          out_pin_b_input_en,
  // io pin A output level for the general-purpose output case
  output logic                          io_a_out_level,
  output logic                          io_pin_a_oe,
  // Input enables and sampled levels toward the core
  output logic                          input_a_enable,
  output logic                          input_b_enable,
  output logic                          in_pin_a_level,
  output logic                          in_pin_b_level,
  output logic                          out_pin_b_level_in
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0] out_pin_function;
    logic       periph_dataout_speed_sel;
    logic [2:0] out_pin_drive_mode;
    logic       input_a_enable;
    logic       input_b_enable;
    logic       io_a_out_level;
    logic       out_b_level;
    logic       io_a_monitor;
    logic       input_a_monitor;
    logic       input_b_monitor;
    mpc_pkg::mpc_reg_rsp_type rsp;
    mpc_pkg::mpc_pad_type     pad;
    logic       keeper_en;
    logic       pin_in_en;
  } mpc_state_type;

  mpc_state_type st_q;
  mpc_state_type st_d;

  logic [3:0] pins_sync;
  logic       lvl_raw;
  logic       lvl_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  mpc_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({io_pin_a_in, in_pin_a_in, in_pin_b_in, out_pin_b_in}),
    .sync_out (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic fn_drives(input logic [3:0] fn);
    case (fn)
      mpc_pkg::FN_GP_OUTPUT,
      mpc_pkg::FN_IRQ,
      mpc_pkg::FN_ASI_MUXED,
      mpc_pkg::FN_DAISY_OUT: fn_drives = 1'b1;
      default:               fn_drives = 1'b0;
    endcase
  endfunction

  // Pad drive style for a level under a drive code
  function automatic mpc_pkg::mpc_pad_type drive_pad(input logic [2:0] drv, input logic lvl);
    mpc_pkg::mpc_pad_type p;
    p.level     = lvl;
    p.strong_en = 1'b0;
    p.weak_en   = 1'b0;
    case (drv)
      mpc_pkg::DRV_PUSH_PULL:  p.strong_en = 1'b1;
      mpc_pkg::DRV_LOW_WEAKHI:
      begin
        p.strong_en = !lvl;
        p.weak_en   = lvl;
      end
      mpc_pkg::DRV_LOW_HIZ:    p.strong_en = !lvl;
      mpc_pkg::DRV_WEAKLO_HI:
      begin
        p.strong_en = lvl;
        p.weak_en   = !lvl;
      end
      mpc_pkg::DRV_HIZ_HI:     p.strong_en = lvl;
      default:                 p.strong_en = 1'b0;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Level source of the output pin by function
  always_comb
  begin
    case (st_q.out_pin_function)
      mpc_pkg::FN_GP_OUTPUT: lvl_raw = st_q.out_b_level;
      mpc_pkg::FN_IRQ:       lvl_raw = irq_level;
      mpc_pkg::FN_ASI_MUXED: lvl_raw = secondary_dout_sel ? secondary_serial_audio_port_dout
                                                          : primary_serial_audio_port_dout;
      mpc_pkg::FN_DAISY_OUT: lvl_raw = daisy_dout;
      default:               lvl_raw = 1'b0;
    endcase
    // Peripheral data-out shares the limiter so the slow option stays rate limited
    if (periph_mode)
      lvl_raw = periph_dataout;
  end

  // Rate limit in every configured function
  mpc_toggle_limit #(
    .GAP_CYC (mpc_pkg::TOGGLE_GAP_CYC)
  ) u_limit (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .level_in  (lvl_raw),
    .level_out (lvl_lim)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.rsp.rvalid = 1'b0;

    if (reg_req.wr_en)
    begin
      case (reg_req.addr)
        mpc_pkg::ADDR_OUT_PIN_FUNCTION_CFG:
        begin
          st_d.out_pin_function         = reg_req.wdata[mpc_pkg::FUNC_LSB +: 4];
          st_d.periph_dataout_speed_sel = reg_req.wdata[mpc_pkg::SPEED_SEL_BIT];
          st_d.out_pin_drive_mode       = reg_req.wdata[mpc_pkg::DRIVE_LSB +: 3];
        end
        mpc_pkg::ADDR_INPUT_PIN_CFG:
        begin
          st_d.input_a_enable = reg_req.wdata[mpc_pkg::IN_A_EN_BIT];
          st_d.input_b_enable = reg_req.wdata[mpc_pkg::IN_B_EN_BIT];
        end
        mpc_pkg::ADDR_PIN_VALUE_MONITOR:
        begin
          st_d.io_a_out_level = reg_req.wdata[mpc_pkg::IO_A_LVL_BIT];
          st_d.out_b_level    = reg_req.wdata[mpc_pkg::OUT_B_LVL_BIT];
        end
        default: ;
      endcase
    end

    // Monitors follow the pins only while configured as inputs
    if (!io_a_out_en)
      st_d.io_a_monitor = pins_sync[3];
    if (st_q.input_a_enable)
      st_d.input_a_monitor = pins_sync[2];
    if (st_q.input_b_enable)
      st_d.input_b_monitor = pins_sync[1];

    if (reg_req.rd_en)
    begin
      st_d.rsp.rvalid = 1'b1;
      case (reg_req.addr)
        mpc_pkg::ADDR_OUT_PIN_FUNCTION_CFG:
          st_d.rsp.rdata = {st_q.out_pin_function, st_q.periph_dataout_speed_sel, st_q.out_pin_drive_mode};
        mpc_pkg::ADDR_INPUT_PIN_CFG:
          st_d.rsp.rdata = {6'h00, st_q.input_a_enable, st_q.input_b_enable} & mpc_pkg::INPUT_CFG_WMASK;
        mpc_pkg::ADDR_PIN_VALUE_MONITOR:
          st_d.rsp.rdata = {st_q.io_a_out_level, 1'b0, st_q.out_b_level, 1'b0,
                            st_q.io_a_monitor, st_q.input_b_monitor,
                            st_q.input_a_monitor, 1'b0};
        default:
          st_d.rsp.rdata = 8'h00;
      endcase
    end

    // Pad control of the output pin
    if (periph_mode)
    begin
      // Function and drive fields ignored; speed bit picks limited or direct path
      st_d.pad.level     = st_q.periph_dataout_speed_sel ? periph_dataout : lvl_lim;
      st_d.pad.strong_en = periph_dataout_en;
      st_d.pad.weak_en   = 1'b0;
      st_d.keeper_en     = 1'b0;
      st_d.pin_in_en     = 1'b0;
    end
    else
    begin
      if (fn_drives(st_q.out_pin_function))
        st_d.pad = drive_pad(st_q.out_pin_drive_mode, lvl_lim);
      else
        st_d.pad = '0;
      st_d.keeper_en = (st_q.out_pin_function != mpc_pkg::FN_ASI_MUXED) &&
                       (st_q.out_pin_function != mpc_pkg::FN_DAISY_OUT) &&
                       (st_q.out_pin_function != mpc_pkg::FN_DISABLED);
      st_d.pin_in_en = (st_q.out_pin_function == mpc_pkg::FN_INPUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.out_pin_function         <= mpc_pkg::RST_OUT_PIN_FUNCTION_CFG[7:4];
      st_q.periph_dataout_speed_sel <= mpc_pkg::RST_OUT_PIN_FUNCTION_CFG[3];
      st_q.out_pin_drive_mode       <= mpc_pkg::RST_OUT_PIN_FUNCTION_CFG[2:0];
      st_q.input_a_enable           <= mpc_pkg::RST_INPUT_PIN_CFG[1];
      st_q.input_b_enable           <= mpc_pkg::RST_INPUT_PIN_CFG[0];
      st_q.io_a_out_level           <= mpc_pkg::RST_PIN_VALUE_MONITOR[7];
      st_q.out_b_level              <= mpc_pkg::RST_PIN_VALUE_MONITOR[5];
    end
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rsp             = st_q.rsp;
  assign out_pin_b_pad       = st_q.pad;
  assign out_pin_b_keeper_en = st_q.keeper_en;
  assign out_pin_b_input_en  = st_q.pin_in_en;
  assign io_a_out_level      = st_q.io_a_out_level;
  assign io_pin_a_oe         = io_a_out_en;
  assign input_a_enable      = st_q.input_a_enable;
  assign input_b_enable      = st_q.input_b_enable;
  assign in_pin_a_level      = st_q.input_a_monitor;
  assign in_pin_b_level      = st_q.input_b_monitor;
  assign out_pin_b_level_in  = pins_sync[0];

endmodule // mpc_pin_config

// [mpc_pin_config_chk.sv]
// Concurrent checks on the ports of the multifunction pin block.
// Assumes one core_clk domain with synchronous active-low rst_b.
module mpc_pin_config_chk (
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     rst_b,
  // Register port
  input wire mpc_pkg::mpc_reg_req_type reg_req,
  input wire mpc_pkg::mpc_reg_rsp_type reg_rsp,
  // Control mode and pins
  input wire logic                     periph_mode,
  input wire logic                     periph_dataout_en,
  input wire mpc_pkg::mpc_pad_type     out_pin_b_pad,
  input wire logic                     out_pin_b_input_en,
  input wire logic                     io_a_out_level,
  input wire logic                     input_a_enable,
  input wire logic                     input_b_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the pad level last changed, saturating
  logic [7:0] gap_q;
  logic       lvl_q;
  always_ff @(posedge core_clk)
  begin
    lvl_q <= out_pin_b_pad.level;
    if (!rst_b)
      gap_q <= 8'hff;
    else if (out_pin_b_pad.level != lvl_q)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  rd_ack_a: assert property (reg_req.rd_en |=> reg_rsp.rvalid)
    else $error("read not answered");
  unmapped_rd_a: assert property (reg_req.rd_en && !(reg_req.addr inside {8'h0c, 8'h0d, 8'h0e})
    |=> reg_rsp.rdata == 8'h00) else $error("unmapped read not zero");
  in_rsvd_a: assert property (reg_req.rd_en && reg_req.addr == 8'h0d |=> reg_rsp.rdata[7:2] == 6'h00)
    else $error("input config reserved bits set");
  val_rsvd_a: assert property (reg_req.rd_en && reg_req.addr == 8'h0e
    |=> {reg_rsp.rdata[6], reg_rsp.rdata[4], reg_rsp.rdata[0]} == 3'h0) else $error("value reserved bits set");
  in_en_wr_a: assert property (reg_req.wr_en && reg_req.addr == 8'h0d
    |=> {input_a_enable, input_b_enable} == $past(reg_req.wdata[1:0])) else $error("input enables wrong");
  io_lvl_wr_a: assert property (reg_req.wr_en && reg_req.addr == 8'h0e
    |=> io_a_out_level == $past(reg_req.wdata[7])) else $error("io level not written");
  in_hiz_a: assert property ((out_pin_b_input_en && !periph_mode)[*3]
    |-> !out_pin_b_pad.strong_en && !out_pin_b_pad.weak_en) else $error("input function drives pad");
  periph_drv_a: assert property ((periph_mode && $stable(periph_dataout_en))[*3]
    |-> out_pin_b_pad.strong_en == periph_dataout_en && !out_pin_b_pad.weak_en) else $error("peripheral drive wrong");
  toggle_gap_a: assert property ((!periph_mode)[*3] ##0 $changed(out_pin_b_pad.level)
    |-> gap_q >= mpc_pkg::TOGGLE_GAP_CYC - 1) else $error("pad toggles too fast");

  cover property (reg_req.rd_en && reg_req.addr == 8'h0e);
  cover property (periph_mode && out_pin_b_pad.strong_en);
  cover property (out_pin_b_input_en);
endmodule // mpc_pin_config_chk

bind mpc_pin_config mpc_pin_config_chk chk_u (.core_clk, .rst_b, .reg_req, .reg_rsp, .periph_mode,
  .periph_dataout_en, .out_pin_b_pad, .out_pin_b_input_en, .io_a_out_level, .input_a_enable, .input_b_enable);

// [tb_mpc_pin_config.sv]
// Self-checking bench for the multifunction pin block.
// Assumes the checker file is compiled with it and binds itself.
module tb_mpc_pin_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk, rst_b;
  mpc_pkg::mpc_reg_req_type req;
  mpc_pkg::mpc_reg_rsp_type rsp;
  mpc_pkg::mpc_pad_type     pad;
  logic                     pm, pdo, pdo_en, irq, pa, sa, ssel, daisy, io_en, io_in, ia_in, ib_in, ob_in;
  logic                     keep, in_en, io_lvl, io_oe, a_en, b_en, a_lvl, b_lvl, ob_lvl;
  int                       errors, total_checks;

  mpc_pin_config dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(req), .reg_rsp(rsp),
    .periph_mode(pm), .periph_dataout(pdo), .periph_dataout_en(pdo_en),
    .irq_level(irq), .primary_serial_audio_port_dout(pa), .secondary_serial_audio_port_dout(sa),
    .secondary_dout_sel(ssel), .daisy_dout(daisy), .io_a_out_en(io_en),
    .io_pin_a_in(io_in), .in_pin_a_in(ia_in), .in_pin_b_in(ib_in), .out_pin_b_in(ob_in),
    .out_pin_b_pad(pad), .out_pin_b_keeper_en(keep), .out_pin_b_input_en(in_en),
    .io_a_out_level(io_lvl), .io_pin_a_oe(io_oe), .input_a_enable(a_en), .input_b_enable(b_en),
    .in_pin_a_level(a_lvl), .in_pin_b_level(b_lvl), .out_pin_b_level_in(ob_lvl)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    req.wr_en = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(negedge core_clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    req.rd_en = 1'b0;
    for (n = 0; n < 4 && rsp.rvalid !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 4)
    begin
      errors++;
      $display("ERROR t=%0t no read response", $time);
      give_verdict();
    end
    chk(rsp.rdata, exp);
  endtask

  // Expected {level, strong, weak}; level only counts while driven
  task automatic pad_is(input logic [2:0] e);
    chk({(pad.strong_en | pad.weak_en) ? pad.level : 1'b0, pad.strong_en, pad.weak_en}, e);
  endtask

  function automatic logic [1:0] drv_exp(input logic [2:0] drv, input logic lvl);
    case (drv)
      3'h1: drv_exp = 2'b10;
      3'h2: drv_exp = lvl ? 2'b01 : 2'b10;
      3'h3: drv_exp = lvl ? 2'b00 : 2'b10;
      3'h4: drv_exp = lvl ? 2'b10 : 2'b01;
      3'h5: drv_exp = lvl ? 2'b10 : 2'b00;
      default: drv_exp = 2'b00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    rdchk(8'h0c, 8'h00);
    rdchk(8'h0d, 8'h00);
    rdchk(8'h0e, 8'h00);
    wr(8'h0c, 8'hdd);
    wr(8'h0b, 8'h00);
    rdchk(8'h0c, 8'hdd);
    rdchk(8'h0b, 8'h00);
    wr(8'h0d, 8'h02);
    rdchk(8'h0d, 8'h02);
    chk({a_en, b_en}, 8'h02);
    wr(8'h0d, 8'h01);
    chk({a_en, b_en}, 8'h01);
    wr(8'h0e, 8'hff);
    rdchk(8'h0e, 8'ha0);
    chk(io_lvl, 8'h01);
  endtask

  task automatic s_mon();
    wr(8'h0d, 8'h03);
    {io_in, ia_in, ib_in, ob_in} = 4'hf;
    tick(5);
    rdchk(8'h0e, 8'hae);
    chk({a_lvl, b_lvl, ob_lvl}, 8'h07);
    wr(8'h0d, 8'h00);
    io_en = 1'b1;
    {io_in, ia_in, ib_in} = 3'h0;
    tick(5);
    rdchk(8'h0e, 8'hae);
    chk(io_oe, 8'h01);
    io_en = 1'b0;
    tick(5);
    rdchk(8'h0e, 8'ha6);
  endtask

  task automatic s_drive();
    logic [1:0] e;
    for (int k = 0; k < 12; k++)
    begin
      wr(8'h0e, {2'b00, k[0], 5'h00});
      wr(8'h0c, {4'h2, 1'b0, k[3:1]});
      tick(16);
      e = drv_exp(k[3:1], k[0]);
      pad_is({k[0] & (e != 2'b00), e});
    end
  endtask

  task automatic s_func();
    logic [2:0] e;
    {irq, pa, sa, ssel, daisy} = 5'b11001;
    wr(8'h0e, 8'h00);
    for (int c = 0; c < 14; c++)
    begin
      wr(8'h0c, {c[3:0], 4'h1});
      tick(16);
      case (c)
        2: e = 3'b010;
        3, 12, 13: e = 3'b110;
        default: e = 3'b000;
      endcase
      pad_is(e);
      chk(in_en, c == 1);
      if (c == 2 || c == 12 || c == 13)
        chk(keep, c == 2);
    end
    ssel = 1'b1;
    wr(8'h0c, 8'hc1);
    tick(16);
    pad_is(3'b010);
    wr(8'h0c, 8'h31);
    tick(16);
    irq = 1'b0;
    tick(4);
    pad_is(3'b010);
    irq = 1'b1;
    tick(5);
    pad_is(3'b010);
    tick(10);
    pad_is(3'b110);
  endtask

  task automatic s_periph();
    wr(8'h0c, 8'h28);
    {pm, pdo_en, pdo} = 3'b111;
    tick(4);
    pad_is(3'b110);
    pdo = 1'b0;
    tick(3);
    pad_is(3'b010);
    pdo = 1'b1;
    tick(3);
    pad_is(3'b110);
    wr(8'h0c, 8'h20);
    tick(16);
    pdo = 1'b0;
    tick(4);
    pad_is(3'b010);
    pdo = 1'b1;
    tick(4);
    pad_is(3'b010);
    tick(12);
    pad_is(3'b110);
    pdo_en = 1'b0;
    tick(3);
    pad_is(3'b000);
  endtask

  initial
  begin
    rst_b = 1'b0;
    req = '0;
    {pm, pdo, pdo_en, irq, pa, sa, ssel, daisy, io_en, io_in, ia_in, ib_in, ob_in} = '0;
    errors = 0;
    total_checks = 0;
    tick(5);
    rst_b = 1'b1;
    pad_is(3'b000);
    s_regs();
    s_mon();
    s_drive();
    s_func();
    s_periph();
    give_verdict();
  end
endmodule // tb_mpc_pin_config
